// *** rtl/sense_pkg.sv ***
// constants shared by the sense byte 1/2 composer and its helpers
package sense_pkg;
	// register word offsets on the bus (byte addresses)
	localparam logic [4:0] OFS_DETAIL_ONE = 5'h00;
	localparam logic [4:0] OFS_DETAIL_TWO = 5'h04;
	localparam logic [4:0] OFS_COMPANION = 5'h08;
	localparam logic [4:0] OFS_CONTROL = 5'h0c;
	localparam int ADR_W = 5;
	// bit positions in a stored byte; sense bit n sits at index 7-n
	localparam int B1_END_CYL = 5;
	localparam int B1_MSG_OPER = 4;
	localparam int B1_NO_RECORD = 3;
	localparam int B1_FILE_PROT = 2;
	localparam int B1_WRITE_INH = 1;
	localparam int B1_OP_INCOMPLETE = 0;
	localparam int B2_UNUSED = 7;
	localparam int B2_CORRECTABLE = 6;
	localparam int B2_ALT_OR_FIRST_LOG = 5;
	localparam int B2_ENV_DATA = 4;
	localparam int B2_INTENT = 3;
	localparam int B2_IMPRECISE = 2;
	localparam int B2_WRITE_OP = 1;
	localparam int B2_FAMILY = 0;
	localparam int B0_CMD_REJECT = 7;
	localparam int B0_EQUIP_CHECK = 4;
	localparam int B0_DATA_CHECK = 3;
	// control register fields
	localparam int CTL_PAGING = 0;
	localparam int CTL_LOGGING = 1;
	// reset values
	localparam logic [7:0] RST_DETAIL_ONE = 8'h00;
	localparam logic [7:0] RST_DETAIL_TWO = 8'h01;
	localparam logic [7:0] RST_COMPANION = 8'h00;
	localparam logic [1:0] RST_CONTROL = 2'h0;
	// second-index watcher states
	typedef enum logic [1:0] {
		IDX_CLEAR = 2'b01,
		IDX_ONE_SEEN = 2'b10
	} idx_state_e;
endpackage

// *** rtl/sense_bus_port.sv ***
// classic wishbone slave front end: one-wait acknowledge and access strobes
`timescale 1ns/1ps
module sense_bus_port (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	output logic wb_ack_o,
	output logic rd_take,
	output logic wr_take
);
	logic ack_q;

	// ack drops the cycle after it is given, so each request is taken once
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
		end
	end

	assign wb_ack_o = ack_q;
	// effects land on the ack edge, while the master still holds the request
	assign rd_take = ack_q & wb_cyc_i & wb_stb_i & ~wb_we_i;
	assign wr_take = ack_q & wb_cyc_i & wb_stb_i & wb_we_i & wb_sel_i[0];
endmodule

// *** rtl/index_pass_watch.sv ***
// flags a second index pass within one chain with no orienting command between
`timescale 1ns/1ps
module index_pass_watch (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic chain_start,
	input wire logic index_seen,
	input wire logic orient_cmd,
	input wire logic accessor_ok,
	output logic second_index
);
	sense_pkg::idx_state_e state_q;
	sense_pkg::idx_state_e state_d;

	always_comb begin
		state_d = state_q;
		second_index = 1'b0;
		case (state_q)
			sense_pkg::IDX_CLEAR: begin
				if (index_seen && !orient_cmd) begin
					state_d = sense_pkg::IDX_ONE_SEEN;
				end
			end
			sense_pkg::IDX_ONE_SEEN: begin
				// no report until the accessor position is confirmed
				if (index_seen && accessor_ok && !orient_cmd) begin
					second_index = 1'b1;
				end
			end
			default: begin
				state_d = sense_pkg::IDX_CLEAR;
			end
		endcase
		if (chain_start || orient_cmd) begin
			state_d = sense_pkg::IDX_CLEAR;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= sense_pkg::IDX_CLEAR;
		end else begin
			state_q <= state_d;
		end
	end
endmodule

// *** rtl/sense_status_bytes_one_two.sv ***
// composer of sense byte 1 bits 2-7 and sense byte 2 with companion bits
//
// Local design decisions: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/1ps
// What this block does
// - A direct: second index pass sets no-record
// - A paging: search-identified record missing sets no-record
// - A destage record missing: no-record, message, env
// - B: second index pass sets no-record
// - seek or multitrack mask violation: file-protected
// - A overflow mask violation: protected plus incomplete
// - B extent boundary overrun sets file-protected
// - A read-only write: inhibited with reject/env
// - B diagnostic inhibit write: inhibited plus equipment
// - A later-segment switch failures set incomplete
// - A segment data checks: incomplete, data, correctable
// - correctable error sets correctable, requests correction in A direct
// - B prefetch retry cure: correctable, check, zero
// - byte 2 bit 2 meaning depends on variant
// - env present means statistics bytes are supplied
// - overflow, logged recovery, destage error: env
// - A invalid destage, and low space or unrelated error in both variants: env
// - B locate write length mismatch: intent violation
// - B missing records or record zero length
// - B exception of earlier command: imprecise ending
// - error during write sets write-operation bit
// - family bit always marks this controller
module sense_status_bytes_one_two #(
	parameter bit VARIANT_B = 1'b0
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	// wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [sense_pkg::ADR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// command execution events, one-cycle pulses from the same clock
	input wire logic chain_start,
	input wire logic index_seen,
	input wire logic orient_cmd,
	input wire logic accessor_ok,
	input wire logic search_miss,
	input wire logic destage_miss,
	input wire logic mask_violation,
	input wire logic overflow_mask_violation,
	input wire logic extent_violation,
	input wire logic base_write_readonly,
	input wire logic destage_write_readonly,
	input wire logic diag_inhibit_write,
	input wire logic seg_protected_track,
	input wire logic seg_cylinder_end,
	input wire logic seg_defect_switch,
	input wire logic seg_seek_error,
	input wire logic seg_uncorrectable,
	input wire logic seg_correctable,
	input wire logic data_correctable,
	input wire logic prefetch_retry_cured,
	input wire logic alt_controller,
	input wire logic soft_log_entered,
	input wire logic counter_overflow,
	input wire logic recovery_ended,
	input wire logic destage_error,
	input wire logic destage_bad_format,
	input wire logic space_low,
	input wire logic unrelated_error,
	input wire logic intent_length_mismatch,
	input wire logic intent_track_miss,
	input wire logic earlier_cmd_exception,
	input wire logic write_active,
	// composed sense state
	output logic [7:0] sense_one,
	output logic [7:0] sense_two,
	output logic [7:0] sense_zero_bits,
	output logic env_stats_req,
	output logic correction_info_req,
	output logic ecc_zero_q
);
	// ==========================================================
	// helpers
	function automatic logic [7:0] bit_at(input int pos, input logic cond);
		bit_at = cond ? (8'h01 << pos) : 8'h00;
	endfunction

	function automatic logic adr_is(input logic [sense_pkg::ADR_W-1:0] a, input logic [sense_pkg::ADR_W-1:0] ofs);
		adr_is = (a == ofs);
	endfunction

	// ==========================================================
	// bus access
	logic rd_take;
	logic wr_take;
	logic fetch_done;
	logic [1:0] control_q;
	logic [7:0] one_q;
	logic [7:0] two_q;
	logic [7:0] zero_q;
	logic paging;
	logic logging;

	sense_bus_port u_bus (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_sel_i(wb_sel_i),
		.wb_ack_o(wb_ack_o),
		.rd_take(rd_take),
		.wr_take(wr_take)
	);

	// reading the second byte ends the fetch: the host reads byte 1 first
	assign fetch_done = rd_take & adr_is(wb_adr_i, sense_pkg::OFS_DETAIL_TWO);
	assign paging = control_q[sense_pkg::CTL_PAGING];
	assign logging = control_q[sense_pkg::CTL_LOGGING];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			control_q <= sense_pkg::RST_CONTROL;
		end else if (wr_take && adr_is(wb_adr_i, sense_pkg::OFS_CONTROL)) begin
			control_q <= wb_dat_i[1:0];
		end
	end

	always_comb begin
		wb_dat_o = 32'h0000_0000;
		case (wb_adr_i)
			sense_pkg::OFS_DETAIL_ONE: wb_dat_o[7:0] = one_q;
			sense_pkg::OFS_DETAIL_TWO: wb_dat_o[7:0] = two_q;
			sense_pkg::OFS_COMPANION: wb_dat_o[7:0] = zero_q;
			sense_pkg::OFS_CONTROL: wb_dat_o[1:0] = control_q;
			default: wb_dat_o = 32'h0000_0000;
		endcase
	end

	// ==========================================================
	// index pass tracking
	logic second_index;
	logic nrf_index;

	index_pass_watch u_idx (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.chain_start(chain_start),
		.index_seen(index_seen),
		.orient_cmd(orient_cmd),
		.accessor_ok(accessor_ok),
		.second_index(second_index)
	);

	// variant A counts only direct mode; variant B also counts cache index
	assign nrf_index = second_index & (VARIANT_B | ~paging);

	// ==========================================================
	// event decode, split by variant
	logic a_var;
	logic nrf;
	logic fp;
	logic wi;
	logic oi;
	logic eoc;
	logic msg;
	logic corr;
	logic bit2_ev;
	logic env;
	logic intent;
	logic imprecise;
	logic rej;
	logic eqc;
	logic dchk;
	logic any_err;

	assign a_var = ~VARIANT_B;
	assign nrf = nrf_index
		| (a_var & paging & search_miss)
		| (a_var & destage_miss);
	assign fp = mask_violation
		| (a_var & overflow_mask_violation)
		| (VARIANT_B & extent_violation)
		| (a_var & seg_protected_track);
	assign wi = (a_var & (base_write_readonly | destage_write_readonly))
		| (VARIANT_B & diag_inhibit_write);
	assign oi = a_var & (overflow_mask_violation | seg_protected_track | seg_cylinder_end
		| seg_defect_switch | seg_seek_error | seg_uncorrectable | seg_correctable);
	assign eoc = a_var & seg_cylinder_end;
	assign msg = a_var & destage_miss;
	assign corr = data_correctable
		| (a_var & seg_correctable)
		| (VARIANT_B & prefetch_retry_cured);
	// byte 2 bit 2: controller selection in A, first error log in B
	assign bit2_ev = VARIANT_B ? soft_log_entered : alt_controller;
	assign env = (a_var & destage_miss) | destage_write_readonly
		| (VARIANT_B & soft_log_entered)
		| counter_overflow | (recovery_ended & logging) | destage_error
		| (a_var & destage_bad_format) | space_low | unrelated_error;
	assign intent = VARIANT_B & (intent_length_mismatch | intent_track_miss);
	assign imprecise = VARIANT_B & earlier_cmd_exception;
	assign rej = a_var & base_write_readonly;
	assign eqc = VARIANT_B & diag_inhibit_write;
	assign dchk = (a_var & (seg_uncorrectable | seg_correctable))
		| (VARIANT_B & prefetch_retry_cured);
	assign any_err = nrf | fp | wi | oi | corr | env | intent | imprecise | dchk;

	// ==========================================================
	// sense bytes: a new event in the fetch cycle survives the clear
	logic [7:0] one_set;
	logic [7:0] two_set;
	logic [7:0] zero_set;

	assign one_set = bit_at(sense_pkg::B1_NO_RECORD, nrf) | bit_at(sense_pkg::B1_FILE_PROT, fp)
		| bit_at(sense_pkg::B1_WRITE_INH, wi) | bit_at(sense_pkg::B1_OP_INCOMPLETE, oi)
		| bit_at(sense_pkg::B1_END_CYL, eoc) | bit_at(sense_pkg::B1_MSG_OPER, msg);
	assign two_set = bit_at(sense_pkg::B2_CORRECTABLE, corr) | bit_at(sense_pkg::B2_ALT_OR_FIRST_LOG, bit2_ev)
		| bit_at(sense_pkg::B2_ENV_DATA, env) | bit_at(sense_pkg::B2_INTENT, intent)
		| bit_at(sense_pkg::B2_IMPRECISE, imprecise)
		| bit_at(sense_pkg::B2_WRITE_OP, any_err & write_active);
	assign zero_set = bit_at(sense_pkg::B0_CMD_REJECT, rej) | bit_at(sense_pkg::B0_EQUIP_CHECK, eqc)
		| bit_at(sense_pkg::B0_DATA_CHECK, dchk);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			one_q <= sense_pkg::RST_DETAIL_ONE;
		end else if (fetch_done) begin
			one_q <= one_set;
		end else begin
			one_q <= one_q | one_set;
		end
	end

	// family bit is forced on and the unused bit forced off in every state
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			two_q <= sense_pkg::RST_DETAIL_TWO;
		end else if (fetch_done) begin
			two_q <= (two_set | bit_at(sense_pkg::B2_FAMILY, 1'b1))
				& ~bit_at(sense_pkg::B2_UNUSED, 1'b1);
		end else begin
			two_q <= (two_q | two_set | bit_at(sense_pkg::B2_FAMILY, 1'b1))
				& ~bit_at(sense_pkg::B2_UNUSED, 1'b1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			zero_q <= sense_pkg::RST_COMPANION;
		end else if (fetch_done) begin
			zero_q <= zero_set;
		end else begin
			zero_q <= zero_q | zero_set;
		end
	end

	// correction detail: real bytes in A direct mode, all zero after a retry cure
	logic corr_req_q;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			corr_req_q <= 1'b0;
			ecc_zero_q <= 1'b0;
		end else if (fetch_done) begin
			corr_req_q <= a_var & ~paging & data_correctable;
			ecc_zero_q <= VARIANT_B & prefetch_retry_cured;
		end else begin
			corr_req_q <= corr_req_q | (a_var & ~paging & data_correctable);
			ecc_zero_q <= ecc_zero_q | (VARIANT_B & prefetch_retry_cured);
		end
	end

	assign sense_one = one_q;
	assign sense_two = two_q;
	assign sense_zero_bits = zero_q;
	// statistics bytes must be filled whenever this is high
	assign env_stats_req = two_q[sense_pkg::B2_ENV_DATA];
	assign correction_info_req = corr_req_q;

	// ==========================================================
	// checks
	sequence s_destage_miss;
		a_var && destage_miss && !fetch_done;
	endsequence

	sequence s_three_bits;
		one_q[sense_pkg::B1_NO_RECORD] && one_q[sense_pkg::B1_MSG_OPER] && two_q[sense_pkg::B2_ENV_DATA];
	endsequence

	AST_DESTAGE_TRIO: assert property (@(posedge ref_clk) disable iff (!rst_n)
		s_destage_miss |=> s_three_bits) else $error("destage miss did not set three bits");

	AST_NRF_INDEX: assert property (@(posedge ref_clk) disable iff (!rst_n)
		nrf_index |=> one_q[sense_pkg::B1_NO_RECORD]) else $error("second index did not set no-record");

	AST_HOLD_UNTIL_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		one_q[sense_pkg::B1_FILE_PROT] && !fetch_done |=> one_q[sense_pkg::B1_FILE_PROT])
		else $error("file protected lost before fetch");

	AST_CLEAR_ON_FETCH: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fetch_done && !fp |=> !one_q[sense_pkg::B1_FILE_PROT]) else $error("fetch did not clear");

	AST_FAMILY_ALWAYS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		two_q[sense_pkg::B2_FAMILY] && !two_q[sense_pkg::B2_UNUSED]) else $error("family or unused bit wrong");

	AST_WRITE_OP: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fp && write_active |=> two_q[sense_pkg::B2_WRITE_OP]) else $error("write operation bit missing");

	AST_OVERFLOW_MASK: assert property (@(posedge ref_clk) disable iff (!rst_n)
		a_var && overflow_mask_violation |=> one_q[sense_pkg::B1_FILE_PROT] && one_q[sense_pkg::B1_OP_INCOMPLETE])
		else $error("overflow mask violation incomplete");

	AST_INHIBIT_PAIR: assert property (@(posedge ref_clk) disable iff (!rst_n)
		VARIANT_B && diag_inhibit_write |=> one_q[sense_pkg::B1_WRITE_INH] && zero_q[sense_pkg::B0_EQUIP_CHECK])
		else $error("inhibit without equipment check");

	AST_LOGGED_RECOVERY: assert property (@(posedge ref_clk) disable iff (!rst_n)
		recovery_ended && !logging && !fetch_done && !$past(two_q[sense_pkg::B2_ENV_DATA]) && !env
		|=> two_q[sense_pkg::B2_ENV_DATA] == $past(two_q[sense_pkg::B2_ENV_DATA]))
		else $error("env set without logging");

	AST_SET_WINS: assert property (@(posedge ref_clk) disable iff (!rst_n)
		fetch_done && fp |=> one_q[sense_pkg::B1_FILE_PROT]) else $error("event lost in fetch cycle");

	AST_READONLY_A: assert property (@(posedge ref_clk) disable iff (!rst_n)
		a_var && base_write_readonly |=> one_q[sense_pkg::B1_WRITE_INH] && zero_q[sense_pkg::B0_CMD_REJECT])
		else $error("read-only write without reject");

	AST_DESTAGE_INHIBIT: assert property (@(posedge ref_clk) disable iff (!rst_n)
		destage_write_readonly |=> two_q[sense_pkg::B2_ENV_DATA]) else $error("inhibited destage without env");

	AST_RETRY_CURE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		VARIANT_B && prefetch_retry_cured |=> two_q[sense_pkg::B2_CORRECTABLE]
		&& zero_q[sense_pkg::B0_DATA_CHECK] && ecc_zero_q) else $error("retry cure bits missing");

	AST_INTENT_B: assert property (@(posedge ref_clk) disable iff (!rst_n)
		VARIANT_B && (intent_length_mismatch || intent_track_miss) |=> two_q[sense_pkg::B2_INTENT])
		else $error("intent violation missing");

	AST_IMPRECISE_B: assert property (@(posedge ref_clk) disable iff (!rst_n)
		VARIANT_B && earlier_cmd_exception |=> two_q[sense_pkg::B2_IMPRECISE])
		else $error("imprecise ending missing");

	AST_FIRST_LOG_B: assert property (@(posedge ref_clk) disable iff (!rst_n)
		VARIANT_B && soft_log_entered |=> two_q[sense_pkg::B2_ALT_OR_FIRST_LOG] && two_q[sense_pkg::B2_ENV_DATA])
		else $error("first error log without env");

	AST_ACK_ONE: assert property (@(posedge ref_clk) disable iff (!rst_n)
		wb_ack_o |=> !wb_ack_o) else $error("ack held two cycles");
endmodule

// *** dv/host_channel_model.sv ***
// host channel model: classic wishbone master that fetches the sense bytes
`timescale 1ns/1ps
module host_channel_model (
	input wire logic ref_clk,
	output logic wb_cyc_i,
	output logic wb_stb_i,
	output logic wb_we_i,
	output logic [sense_pkg::ADR_W-1:0] wb_adr_i,
	output logic [3:0] wb_sel_i,
	output logic [31:0] wb_dat_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o
);
	initial begin
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 5'h1f;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
	end
	// ==========================================================
	// one classic cycle; idle address and data lines are inverted so stale values never pass
	task automatic xfer(input logic [sense_pkg::ADR_W-1:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] q, output bit late);
		int n;
		@(posedge ref_clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_sel_i <= 4'hf;
		wb_dat_i <= d;
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 16);
		q = wb_dat_o;
		late = (wb_ack_o !== 1'b1);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i <= 1'b0;
		wb_adr_i <= ~a;
		wb_dat_i <= ~d;
	endtask
endmodule

// *** dv/tb.sv ***
// self-checking bench: both variants of the sense composer side by side
`timescale 1ns/1ps
module tb;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] ev = 32'h0;
	int errors = 0;
	int num_checks = 0;
	wire chain_start, index_seen, orient_cmd, accessor_ok, search_miss, destage_miss, mask_violation;
	wire overflow_mask_violation, extent_violation, base_write_readonly, destage_write_readonly;
	wire diag_inhibit_write, seg_protected_track, seg_cylinder_end, seg_defect_switch, seg_seek_error;
	wire seg_uncorrectable, seg_correctable, data_correctable, prefetch_retry_cured, alt_controller;
	wire soft_log_entered, counter_overflow, recovery_ended, destage_error, destage_bad_format, space_low;
	wire unrelated_error, intent_length_mismatch, intent_track_miss, earlier_cmd_exception, write_active;
	// event bit k: chain_start is bit 0, write_active bit 31, in port order
	assign {write_active, earlier_cmd_exception, intent_track_miss, intent_length_mismatch, unrelated_error,
		space_low, destage_bad_format, destage_error, recovery_ended, counter_overflow, soft_log_entered,
		alt_controller, prefetch_retry_cured, data_correctable, seg_correctable, seg_uncorrectable,
		seg_seek_error, seg_defect_switch, seg_cylinder_end, seg_protected_track, diag_inhibit_write,
		destage_write_readonly, base_write_readonly, extent_violation, overflow_mask_violation,
		mask_violation, destage_miss, search_miss, accessor_ok, orient_cmd, index_seen, chain_start} = ev;
	always #2 ref_clk = ~ref_clk;
	// ==========================================================
	// instance 0 is variant a, instance 1 variant b
	for (genvar i = 0; i < 2; i++) begin : g
		logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
		logic [sense_pkg::ADR_W-1:0] wb_adr_i;
		logic [3:0] wb_sel_i;
		logic [31:0] wb_dat_i, wb_dat_o;
		logic [7:0] sense_one, sense_two, sense_zero_bits;
		logic env_stats_req, correction_info_req, ecc_zero_q;
		sense_status_bytes_one_two #(.VARIANT_B(i == 1)) sense_status_bytes_one_two_inst (.*);
		host_channel_model host_channel_model_inst (.*);
	end
	// ==========================================================
	task automatic final_report();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
		num_checks++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", n, e, s);
			errors++;
		end
	endtask
	task automatic bus(input int i, input logic [4:0] a, input logic w, input logic [31:0] d, output logic [31:0] q);
		bit late;
		if (i == 0) g[0].host_channel_model_inst.xfer(a, w, d, q, late);
		else g[1].host_channel_model_inst.xfer(a, w, d, q, late);
		if (late) begin
			$display("ERROR wb_ack_o expected 1 seen 0");
			errors++;
			final_report();
		end
	endtask
	task automatic rd(input int i, input logic [4:0] a, input logic [31:0] e, input string n);
		logic [31:0] q;
		bus(i, a, 1'b0, 32'h0, q);
		chk(n, e, q);
	endtask
	task automatic ctl(input logic [31:0] v);
		logic [31:0] q;
		for (int i = 0; i < 2; i++) begin
			bus(i, sense_pkg::OFS_CONTROL, 1'b1, v, q);
			rd(i, sense_pkg::OFS_CONTROL, v, "control");
		end
	endtask
	task automatic fire(input logic [31:0] m);
		@(posedge ref_clk);
		ev <= m;
		@(posedge ref_clk);
		ev <= 32'h0;
	endtask
	// expectations packed as {byte 1, byte 2, byte 0 companions} per variant
	task automatic case_chk(input logic [31:0] m, input logic [23:0] ea, input logic [23:0] eb, input bit full);
		logic [23:0] e;
		logic [24:0] s;
		fire(m);
		@(negedge ref_clk);
		for (int i = 0; i < 2; i++) begin
			e = i ? eb : ea;
			s = i ? {g[1].env_stats_req, g[1].sense_one, g[1].sense_two, g[1].sense_zero_bits}
				: {g[0].env_stats_req, g[0].sense_one, g[0].sense_two, g[0].sense_zero_bits};
			chk("env_stats_req", {31'h0, e[12]}, {31'h0, s[24]});
			chk("sense_one", {24'h0, e[23:16]}, {24'h0, s[23:16]});
			chk("sense_two", {24'h0, e[15:8]}, {24'h0, s[15:8]});
			chk("sense_zero_bits", {24'h0, e[7:0]}, {24'h0, s[7:0]});
			rd(i, sense_pkg::OFS_DETAIL_ONE, {24'h0, e[23:16]}, "detail_one");
			if (full) rd(i, sense_pkg::OFS_COMPANION, {24'h0, e[7:0]}, "companion");
			rd(i, sense_pkg::OFS_DETAIL_TWO, {24'h0, e[15:8]}, "detail_two");
			rd(i, sense_pkg::OFS_DETAIL_ONE, 32'h0, "cleared_one");
			rd(i, sense_pkg::OFS_DETAIL_TWO, 32'h1, "cleared_two");
		end
	endtask
	// ==========================================================
	task automatic t_reset();
		logic [31:0] q;
		for (int i = 0; i < 2; i++) begin
			rd(i, sense_pkg::OFS_DETAIL_ONE, 32'h0, "rst_one");
			rd(i, sense_pkg::OFS_DETAIL_TWO, 32'h1, "rst_two");
			rd(i, sense_pkg::OFS_COMPANION, 32'h0, "rst_companion");
			rd(i, sense_pkg::OFS_CONTROL, 32'h0, "rst_control");
			bus(i, sense_pkg::OFS_DETAIL_ONE, 1'b1, 32'hff, q);
			rd(i, sense_pkg::OFS_DETAIL_ONE, 32'h0, "ro_one");
			bus(i, 5'h10, 1'b1, 32'h3, q);
			rd(i, 5'h10, 32'h0, "unmapped");
		end
	endtask
	task automatic t_mask();
		case_chk(32'h00000040, 24'h040100, 24'h040100, 1'b1);
		case_chk(32'h80000040, 24'h040300, 24'h040300, 1'b1);
		case_chk(32'h00000080, 24'h050100, 24'h000100, 1'b1);
		case_chk(32'h00000100, 24'h000100, 24'h040100, 1'b1);
	endtask
	task automatic t_index();
		fire(32'h00000001);
		fire(32'h00000002);
		case_chk(32'h0000000a, 24'h080100, 24'h080100, 1'b1);
		fire(32'h00000001);
		fire(32'h00000002);
		fire(32'h00000004);
		case_chk(32'h0000000a, 24'h000100, 24'h000100, 1'b1);
	endtask
	task automatic t_paging();
		ctl(32'h1);
		case_chk(32'h00000010, 24'h080100, 24'h000100, 1'b1);
		case_chk(32'h00000020, 24'h181100, 24'h000100, 1'b1);
		ctl(32'h0);
	endtask
	task automatic t_inhibit();
		case_chk(32'h00000200, 24'h020180, 24'h000100, 1'b1);
		case_chk(32'h00000400, 24'h021100, 24'h001100, 1'b1);
		case_chk(32'h00000800, 24'h000100, 24'h020110, 1'b1);
	endtask
	task automatic t_segments();
		case_chk(32'h00001000, 24'h050100, 24'h000100, 1'b1);
		case_chk(32'h00002000, 24'h210100, 24'h000100, 1'b1);
		case_chk(32'h0000c000, 24'h010100, 24'h000100, 1'b1);
		case_chk(32'h00010000, 24'h010108, 24'h000100, 1'b1);
		case_chk(32'h00020000, 24'h014108, 24'h000100, 1'b1);
	endtask
	task automatic t_correct();
		fire(32'h00040000);
		@(negedge ref_clk);
		chk("correction_a", 32'h1, {31'h0, g[0].correction_info_req});
		chk("correction_b", 32'h0, {31'h0, g[1].correction_info_req});
		case_chk(32'h0, 24'h004100, 24'h004100, 1'b0);
		@(negedge ref_clk);
		chk("correction_cleared", 32'h0, {31'h0, g[0].correction_info_req});
		fire(32'h00080000);
		@(negedge ref_clk);
		chk("ecc_zero", 32'h1, {31'h0, g[1].ecc_zero_q});
		case_chk(32'h0, 24'h000100, 24'h004108, 1'b1);
		@(negedge ref_clk);
		chk("ecc_zero_cleared", 32'h0, {31'h0, g[1].ecc_zero_q});
		case_chk(32'h00100000, 24'h002100, 24'h000100, 1'b1);
		case_chk(32'h00200000, 24'h000100, 24'h003100, 1'b1);
	endtask
	task automatic t_env();
		case_chk(32'h00400000, 24'h001100, 24'h001100, 1'b1);
		case_chk(32'h00800000, 24'h000100, 24'h000100, 1'b1);
		ctl(32'h2);
		case_chk(32'h00800000, 24'h001100, 24'h001100, 1'b1);
		ctl(32'h0);
		case_chk(32'h01000000, 24'h001100, 24'h001100, 1'b1);
		case_chk(32'h02000000, 24'h001100, 24'h000100, 1'b1);
		case_chk(32'h0c000000, 24'h001100, 24'h001100, 1'b1);
	endtask
	task automatic t_intent();
		case_chk(32'h10000000, 24'h000100, 24'h000900, 1'b1);
		case_chk(32'h20000000, 24'h000100, 24'h000900, 1'b1);
		case_chk(32'h40000000, 24'h000100, 24'h000500, 1'b1);
	endtask
	// an event standing through the fetch edge must survive the clear
	task automatic t_set_wins();
		for (int i = 0; i < 2; i++) begin
			ev <= 32'h00000040;
			rd(i, sense_pkg::OFS_DETAIL_TWO, 32'h1, "fetch_two");
			ev <= 32'h0;
			rd(i, sense_pkg::OFS_DETAIL_ONE, 32'h4, "kept_one");
			rd(i, sense_pkg::OFS_DETAIL_TWO, 32'h1, "kept_two");
			rd(i, sense_pkg::OFS_DETAIL_ONE, 32'h0, "gone_one");
		end
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'b1;
		t_reset();
		t_mask();
		t_index();
		t_paging();
		t_inhibit();
		t_segments();
		t_correct();
		t_env();
		t_intent();
		t_set_wins();
		final_report();
	end
endmodule
